//--- hw/dpsc_core.sv
`timescale 1ns/1ps
`default_nettype none
// Serial command unit: framing, decode, tap register and slot sequencing.
module dpsc_core (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // Serial pins from the host
   input wire logic csN,
   input wire logic sclk,
   input wire logic sdi,
   // Serial output
   output logic sdo,
   output logic sdoOe,
   // Potentiometer state
   output logic [7:0] tapValue,
   output logic bufferOn,
   output logic asleep
);
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_FETCH,
      ST_APPLY
   } dpsc_seq_t;

   typedef struct packed {
      logic [2:0] csSync;
      logic [2:0] clkSync;
      logic [2:0] sdiSync;
      logic csLvl;
      logic clkLvl;
      logic [23:0] shiftIn;
      logic [23:0] shiftOut;
      logic [23:0] frame;
      logic [4:0] bitCnt;
      logic cntOver;
      logic [7:0] tap;
      logic mode;
      logic sleep;
      logic [8:0] readRes;
      logic readPend;
      dpsc_seq_t seq;
      logic memWe;
      logic [1:0] memAddr;
      logic [8:0] memData;
      logic sdoBit;
      logic oe;
   } dpsc_state_t;

   dpsc_state_t state_ff;
   dpsc_state_t nxt_state;
   logic [8:0] memRd;
   logic csLow;
   logic clkHigh;
   logic csRise;
   logic csFall;
   logic clkRise;
   logic clkFall;
   dpsc_pkg::dpsc_op_t op;

   // Agreement of the second and third sync stages gives the filtered levels.
   function automatic logic filt(input logic [2:0] s, input logic prev);
      filt = (s[1] == s[2]) ? s[1] : prev;
   endfunction

   // Saturating step of the tap value.
   function automatic logic [7:0] stepTap(input logic [7:0] t, input logic up);
      if (up)
      begin
         stepTap = (t == dpsc_pkg::TAP_MAX) ? t : t + 8'h01;
      end
      else
      begin
         stepTap = (t == dpsc_pkg::TAP_MIN) ? t : t - 8'h01;
      end
   endfunction

   dpsc_slot_mem #(
      .WIDTH(dpsc_pkg::SLOT_BITS),
      .DEPTH(dpsc_pkg::SLOT_COUNT)
   ) u_mem (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .wrEn(state_ff.memWe),
      .wrAddr(state_ff.memAddr),
      .wrData(state_ff.memData),
      .rdAddr(state_ff.frame[dpsc_pkg::SLOT_MSB:dpsc_pkg::SLOT_LSB]), // Read ahead of apply.
      .rdData(memRd)
   );

   // Filtered pin levels and their edges.
   always_comb
   begin
      csLow = ~filt(state_ff.csSync, state_ff.csLvl);
      clkHigh = filt(state_ff.clkSync, state_ff.clkLvl);
      csFall = state_ff.csLvl & csLow;
      csRise = ~state_ff.csLvl & ~csLow;
      clkRise = ~state_ff.clkLvl & clkHigh;
      clkFall = state_ff.clkLvl & ~clkHigh;
      op = dpsc_pkg::dpsc_op_t'(state_ff.frame[dpsc_pkg::OPC_MSB:dpsc_pkg::OPC_LSB]);
   end

   // Next-state logic for framing, shifting and command execution.
   always_comb
   begin
      nxt_state = state_ff;
      nxt_state.csSync = {state_ff.csSync[1:0], csN};
      nxt_state.clkSync = {state_ff.clkSync[1:0], sclk};
      nxt_state.sdiSync = {state_ff.sdiSync[1:0], sdi};
      nxt_state.csLvl = ~csLow;
      nxt_state.clkLvl = clkHigh;
      nxt_state.memWe = 1'b0;

      if (csFall)
      begin
         nxt_state.bitCnt = dpsc_pkg::CNT_RST;
         nxt_state.cntOver = 1'b0;
         nxt_state.oe = 1'b1;
         nxt_state.shiftOut = state_ff.shiftIn;
         // result goes into the next frame
         if (state_ff.readPend)
         begin
            // mode then tap in data bits
            nxt_state.shiftOut[dpsc_pkg::MODE_POS:0] = state_ff.readRes;
            nxt_state.readPend = 1'b0;
         end
         nxt_state.sdoBit = nxt_state.shiftOut[dpsc_pkg::FRAME_BITS-1];
      end
      else if (csLow && clkRise)
      begin
         nxt_state.shiftIn = {state_ff.shiftIn[22:0], state_ff.sdiSync[2]};
         if (state_ff.bitCnt == dpsc_pkg::CNT_FULL)
         begin
            nxt_state.cntOver = 1'b1;
         end
         else
         begin
            nxt_state.bitCnt = state_ff.bitCnt + 5'h01;
         end
      end
      else if (csLow && clkFall)
      begin
         nxt_state.shiftOut = {state_ff.shiftOut[22:0], 1'b0};
         nxt_state.sdoBit = state_ff.shiftOut[dpsc_pkg::FRAME_BITS-2];
      end

      if (csRise)
      begin
         nxt_state.oe = 1'b0;
         if (state_ff.bitCnt == dpsc_pkg::CNT_FULL && !state_ff.cntOver &&
            (!state_ff.sleep ||
            state_ff.shiftIn[dpsc_pkg::OPC_MSB:dpsc_pkg::OPC_LSB] == dpsc_pkg::OP_WAKE))
         begin
            nxt_state.frame = state_ff.shiftIn;
            nxt_state.seq = ST_FETCH;
         end
      end

      unique case (state_ff.seq)
         ST_IDLE:
         begin
            nxt_state.seq = nxt_state.seq;
         end
         ST_FETCH:
         begin
            nxt_state.memAddr = state_ff.frame[dpsc_pkg::SLOT_MSB:dpsc_pkg::SLOT_LSB];
            nxt_state.seq = ST_APPLY; // Internal slot-zero reloads run even while asleep.
         end
         ST_APPLY:
         begin
            nxt_state.seq = ST_IDLE;
            unique case (op)
               dpsc_pkg::OP_WAKE: nxt_state.sleep = 1'b0;
               dpsc_pkg::OP_SLEEP: nxt_state.sleep = 1'b1;
               dpsc_pkg::OP_RESET:
               begin
                  // software reset recalls slot zero and sleeps
                  nxt_state.sleep = 1'b1;
                  nxt_state.memAddr = 2'b00;
                  nxt_state.seq = ST_FETCH;
                  nxt_state.frame[dpsc_pkg::OPC_MSB:dpsc_pkg::OPC_LSB] = dpsc_pkg::OP_LOAD;
                  nxt_state.frame[dpsc_pkg::SLOT_MSB:dpsc_pkg::SLOT_LSB] = 2'b00;
               end
               dpsc_pkg::OP_WRITE: nxt_state.tap = state_ff.frame[7:0];
               dpsc_pkg::OP_UP: nxt_state.tap = stepTap(state_ff.tap, 1'b1);
               dpsc_pkg::OP_DOWN: nxt_state.tap = stepTap(state_ff.tap, 1'b0);
               dpsc_pkg::OP_LOAD:
               begin
                  nxt_state.tap = memRd[7:0];
                  nxt_state.mode = memRd[dpsc_pkg::MODE_POS];
               end
               dpsc_pkg::OP_ERASE:
               begin
                  nxt_state.memWe = 1'b1;
                  nxt_state.memData = dpsc_pkg::ERASED;
               end
               dpsc_pkg::OP_PROG:
               begin
                  nxt_state.memWe = 1'b1;
                  nxt_state.memData = state_ff.frame[dpsc_pkg::MODE_POS:0];
               end
               dpsc_pkg::OP_STORE:
               begin
                  nxt_state.memWe = 1'b1;
                  nxt_state.memData = {state_ff.mode, state_ff.tap};
               end
               dpsc_pkg::OP_RDSLOT:
               begin
                  nxt_state.readRes = memRd;
                  nxt_state.readPend = 1'b1;
               end
               dpsc_pkg::OP_RDTAP:
               begin
                  nxt_state.readRes = {state_ff.mode, state_ff.tap};
                  nxt_state.readPend = 1'b1;
               end
               default: nxt_state.seq = ST_IDLE;
            endcase
         end
      endcase
   end

   // power-up starts asleep; slot zero is recalled via reset load.
   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
      begin
         state_ff <= '0;
         state_ff.csSync <= 3'h7;
         state_ff.csLvl <= 1'b1;
         state_ff.tap <= dpsc_pkg::TAP_RST;
         state_ff.sleep <= 1'b1;
         state_ff.seq <= ST_FETCH;
         state_ff.frame <= {dpsc_pkg::OP_LOAD, 20'h00000};
      end
      else
      begin
         state_ff <= nxt_state;
      end
   end

   // mode bit one means buffer on.
   always_comb
   begin
      sdo = state_ff.sdoBit;
      sdoOe = state_ff.oe;
      tapValue = state_ff.tap;
      bufferOn = state_ff.mode;
      asleep = state_ff.sleep;
   end
endmodule // dpsc_core
`default_nettype wire

//--- hw/dpsc_pkg.sv
package dpsc_pkg;
   localparam int FRAME_BITS = 24;
   localparam int TAP_BITS = 8;
   localparam int SLOT_BITS = 9;
   localparam int SLOT_COUNT = 4;
   // Field positions within the 24-bit frame.
   localparam int OPC_MSB = 23;
   localparam int OPC_LSB = 20;
   localparam int SLOT_MSB = 19;
   localparam int SLOT_LSB = 18;
   localparam int MODE_POS = 8;
   // Reset values, erased slot word and limits.
   localparam logic [7:0] TAP_RST = 8'h00;
   localparam logic [8:0] SLOT_RST = 9'h000;
   localparam logic [8:0] ERASED = 9'h1ff;
   localparam logic [4:0] CNT_RST = 5'h00;
   localparam logic [4:0] CNT_FULL = 5'h18;
   localparam logic [7:0] TAP_MAX = 8'hff;
   localparam logic [7:0] TAP_MIN = 8'h00;
   // Store wait time (host obligation) for reference.
   localparam int STORE_WAIT_MS = 2;
   localparam int CLK_HZ = 20000000;
   localparam int STORE_WAIT_CYC = STORE_WAIT_MS * (CLK_HZ / 1000);
   // Pin synchroniser depth.
   localparam int SYNC_STAGES = 3;
   typedef enum logic [3:0] {
      OP_NOP = 4'h0,
      OP_WAKE = 4'h1,
      OP_PROG = 4'h2,
      OP_STORE = 4'h3,
      OP_WRITE = 4'h4,
      OP_UP = 4'h7,
      OP_SLEEP = 4'h8,
      OP_RESET = 4'h9,
      OP_RDSLOT = 4'ha,
      OP_LOAD = 4'hb,
      OP_RDTAP = 4'hc,
      OP_ERASE = 4'hd,
      OP_DOWN = 4'hf
   } dpsc_op_t;
endpackage : dpsc_pkg

//--- hw/dpsc_slot_mem.sv
`timescale 1ns/1ps
`default_nettype none
// Four nine-bit slots; read data leaves through a register.
module dpsc_slot_mem #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // Write port
   input wire logic wrEn,
   input wire logic [$clog2(DEPTH)-1:0] wrAddr,
   input wire logic [WIDTH-1:0] wrData,
   // Read port
   input wire logic [$clog2(DEPTH)-1:0] rdAddr,
   output logic [WIDTH-1:0] rdData
);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [WIDTH-1:0] rd;
   } dpsc_mem_t;
   dpsc_mem_t state_ff;
   dpsc_mem_t nxt_state;

   // Write selected word and register the read word.
   always_comb
   begin
      nxt_state = state_ff;
      if (wrEn)
      begin
         nxt_state.mem[wrAddr] = wrData;
      end
      nxt_state.rd = state_ff.mem[rdAddr];
   end

   // Slots come up cleared.
   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
      begin
         state_ff <= '0;
      end
      else
      begin
         state_ff <= nxt_state;
      end
   end

   assign rdData = state_ff.rd;
endmodule // dpsc_slot_mem
`default_nettype wire

//--- tb/dpsc_core_checker.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level checks of the serial command unit.
module dpsc_core_checker (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // Serial pins
   input wire logic csN,
   input wire logic sclk,
   input wire logic sdi,
   input wire logic sdo,
   input wire logic sdoOe,
   // Potentiometer state
   input wire logic [7:0] tapValue,
   input wire logic bufferOn,
   input wire logic asleep
);
   logic csPrev_ff;
   logic [3:0] sinceCs_ff;
   logic [3:0] sleepCnt_ff;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!resetn);
   // Counts cycles since select rose and since sleep began.
   always_ff @(posedge clk_sys)
   begin
      csPrev_ff <= csN;
      if (!resetn || (csN && !csPrev_ff))
         sinceCs_ff <= 4'h0;
      else if (sinceCs_ff != 4'hf)
         sinceCs_ff <= sinceCs_ff + 4'h1;
      if (!resetn || !asleep)
         sleepCnt_ff <= 4'h0;
      else if (sleepCnt_ff != 4'hf)
         sleepCnt_ff <= sleepCnt_ff + 4'h1;
   end
   sequence csIdle;
      csN [*6];
   endsequence
   sequence clkHigh;
      sclk [*2];
   endsequence
   oe_idle_a: assert property (csIdle |-> !sdoOe)
      else $error("output enabled outside a frame");
   oe_rise_a: assert property ($rose(sdoOe) |-> !csN && !$past(csN, 2))
      else $error("output enabled without select");
   oe_fall_a: assert property ($fell(sdoOe) |-> csN && $past(csN, 2))
      else $error("output released while selected");
   sdo_hold_a: assert property (clkHigh |-> $stable(sdo))
      else $error("serial output moved while clock high");
   tap_after_frame_a: assert property ($changed(tapValue) |-> sinceCs_ff <= 4'ha)
      else $error("tap changed away from frame end");
   mode_after_frame_a: assert property ($changed(bufferOn) |-> sinceCs_ff <= 4'ha)
      else $error("mode changed away from frame end");
   sleep_after_frame_a: assert property ($changed(asleep) |-> sinceCs_ff <= 4'ha)
      else $error("sleep state changed away from frame end");
   sleep_hold_a: assert property (asleep && sleepCnt_ff > 4'h5 |->
      $stable(tapValue) && $stable(bufferOn))
      else $error("setting changed while asleep");
endmodule // dpsc_core_checker
bind dpsc_core dpsc_core_checker chk (.clk_sys(clk_sys), .resetn(resetn), .csN(csN),
   .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdoOe(sdoOe), .tapValue(tapValue),
   .bufferOn(bufferOn), .asleep(asleep));
`default_nettype wire

//--- tb/dpsc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Host master: drives select, clock and data and captures the serial output.
module dpsc_host_model (
   // Clock
   input wire logic clk_sys,
   // Serial pins
   output logic csN,
   output logic sclk,
   output logic sdi,
   input wire logic sdo
);
   // Pins idle with select high and the clock low.
   initial
   begin
      csN = 1'b1;
      sclk = 1'b0;
      sdi = 1'b0;
   end
   task automatic frame(input logic [23:0] cmd, input int nClk, output logic [23:0] rx);
      rx = 24'h000000;
      @(negedge clk_sys) csN = 1'b0;
      repeat (4) @(negedge clk_sys);
      for (int i = 0; i < nClk; i++)
      begin
         sdi = cmd[23 - (i % 24)];
         repeat (6) @(negedge clk_sys);
         rx = {rx[22:0], sdo};
         sclk = 1'b1;
         repeat (4) @(negedge clk_sys);
         sclk = 1'b0;
      end
      repeat (4) @(negedge clk_sys);
      csN = 1'b1;
      sdi = ~sdi;
      repeat (16) @(negedge clk_sys);
   endtask
endmodule // dpsc_host_model
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the serial command unit.
module tb_top;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic csN;
   logic sclk;
   logic sdi;
   logic sdo;
   logic sdoOe;
   logic bufferOn;
   logic asleep;
   logic [7:0] tapValue;
   logic [23:0] rx;
   int num_errors = 0;
   int checked = 0;
   // Clock with a 50 ns period.
   always #25 clk_sys = ~clk_sys;
   dpsc_core uut (.clk_sys(clk_sys), .resetn(resetn), .csN(csN), .sclk(sclk), .sdi(sdi),
      .sdo(sdo), .sdoOe(sdoOe), .tapValue(tapValue), .bufferOn(bufferOn), .asleep(asleep));
   dpsc_host_model host (.clk_sys(clk_sys), .csN(csN), .sclk(sclk), .sdi(sdi), .sdo(sdo));
   function automatic logic [23:0] mk(input logic [3:0] op, input logic [1:0] s,
      input logic [8:0] d);
      return {op, s, 2'b00, 7'h00, d};
   endfunction
   task automatic send(input logic [3:0] op, input logic [1:0] s = 2'h0,
      input logic [8:0] d = 9'h000, input int n = 24);
      host.frame(mk(op, s, d), n, rx);
   endtask
   task automatic cmp_state(input logic [7:0] t, input logic m, input logic z);
      checked++;
      if ({tapValue, bufferOn, asleep} !== {t, m, z})
      begin
         num_errors++;
         $display("mismatch state expected %h seen %h", {t, m, z}, {tapValue, bufferOn, asleep});
      end
   endtask
   task automatic cmp_word(input string what, input logic [23:0] e, input logic [23:0] g);
      checked++;
      if (g !== e)
      begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic t_tap;
      send(dpsc_pkg::OP_WRITE, 2'h0, 9'h055);
      cmp_state(8'h00, 1'b0, 1'b1);
      send(dpsc_pkg::OP_WAKE);
      send(dpsc_pkg::OP_WRITE, 2'h0, 9'h0fe);
      cmp_state(8'hfe, 1'b0, 1'b0);
      send(dpsc_pkg::OP_UP);
      cmp_state(8'hff, 1'b0, 1'b0);
      send(dpsc_pkg::OP_UP);
      cmp_state(8'hff, 1'b0, 1'b0);
      send(dpsc_pkg::OP_DOWN);
      cmp_state(8'hfe, 1'b0, 1'b0);
      send(dpsc_pkg::OP_WRITE);
      send(dpsc_pkg::OP_DOWN);
      cmp_state(8'h00, 1'b0, 1'b0);
      send(dpsc_pkg::OP_WRITE, 2'h0, 9'h077, 23);
      send(dpsc_pkg::OP_WRITE, 2'h0, 9'h077, 25);
      cmp_state(8'h00, 1'b0, 1'b0);
      $display("test tap done");
   endtask
   task automatic t_slot;
      send(dpsc_pkg::OP_ERASE, 2'h2);
      send(dpsc_pkg::OP_PROG, 2'h2, 9'h1a5);
      send(dpsc_pkg::OP_WRITE, 2'h0, 9'h011);
      send(dpsc_pkg::OP_NOP);
      cmp_word("echo", mk(dpsc_pkg::OP_WRITE, 2'h0, 9'h011), rx);
      cmp_state(8'h11, 1'b0, 1'b0);
      send(dpsc_pkg::OP_LOAD, 2'h2);
      cmp_state(8'ha5, 1'b1, 1'b0);
      send(dpsc_pkg::OP_WRITE, 2'h0, 9'h03c);
      send(dpsc_pkg::OP_ERASE, 2'h3);
      send(dpsc_pkg::OP_STORE, 2'h3);
      send(dpsc_pkg::OP_WRITE, 2'h0, 9'h044);
      send(dpsc_pkg::OP_RDSLOT, 2'h3);
      cmp_word("read frame", {15'h0, 9'h044}, {15'h0, rx[8:0]});
      send(dpsc_pkg::OP_RDTAP);
      cmp_word("slot", {15'h0, 9'h13c}, {15'h0, rx[8:0]});
      send(dpsc_pkg::OP_NOP);
      cmp_word("tap", {15'h0, 9'h144}, {15'h0, rx[8:0]});
      $display("test slot done");
   endtask
   task automatic t_power;
      send(dpsc_pkg::OP_SLEEP);
      send(dpsc_pkg::OP_WRITE, 2'h0, 9'h099);
      cmp_state(8'h44, 1'b1, 1'b1);
      send(dpsc_pkg::OP_WAKE);
      send(dpsc_pkg::OP_RESET);
      cmp_state(8'h00, 1'b0, 1'b1);
      $display("test power done");
   endtask
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // Main sequence after a reset of three cycles.
   initial
   begin
      repeat (3) @(negedge clk_sys);
      resetn = 1'b1;
      repeat (4) @(negedge clk_sys);
      cmp_state(8'h00, 1'b0, 1'b1);
      t_tap();
      t_slot();
      t_power();
      finish_test();
   end
   // Watchdog well beyond the expected run length.
   initial
   begin
      repeat (30000) @(posedge clk_sys);
      num_errors++;
      finish_test();
   end
endmodule // tb_top
`default_nettype wire
